// ===== design/bls_bus_sizer.sv
`timescale 1ns/1ps
// Behaviour
// - Lane select asserted only for participating bytes.
// - Asserted lane selects always contiguous.
// - Bus cycle lasts at least two states.
// - Operands crossing a dword boundary split into several cycles.
// - Memory full range, programmed I/O 64 KB.
// - Coprocessor I/O at eight addresses from 800000F8.
// - Upper 30 address bits driven directly.
// - Half-width input sampled every bus cycle.
// - Half-width cycles carry bytes on low lines.
// - Low-half-only lanes ignore half-width input.
// - Upper-only half-width reads use low lines.
// - Upper-only writes copy upper onto lower.
// - Split reads: bytes 0-1 then 2-3.
// - Split writes copy bytes 2-3 second.
// - Second split cycle keeps lanes 0-1 negated.
module bls_bus_sizer (
	clk,
	reset,
	req_valid,
	req,
	req_ready,
	rd_valid,
	rd_data,
	bus_start,
	bus_write,
	bus_mem,
	byte_lane_select_n,
	dword_address,
	data_lines_in,
	data_lines_out,
	data_lines_oe,
	half_width_port_n,
	ready_n
);
	input wire logic clk;
	input wire logic reset;
	input wire logic req_valid;
	input bls_pkg::bls_req_t req;
	output logic req_ready;
	output logic rd_valid;
	output logic [31:0] rd_data;
	output logic bus_start;
	output logic bus_write;
	output logic bus_mem;
	output logic [3:0] byte_lane_select_n;
	output logic [29:0] dword_address;
	input wire logic [31:0] data_lines_in;
	output logic [31:0] data_lines_out;
	output logic data_lines_oe;
	input wire logic half_width_port_n;
	input wire logic ready_n;

	bls_pkg::bls_state_t st_q;
	bls_pkg::bls_req_t head;
	logic head_valid;
	logic [3:0] gen_lo;
	logic [3:0] gen_hi;
	logic [29:0] gen_dw;
	logic [63:0] gen_wide;

	logic [3:0] lo_q;
	logic [29:0] base_q;
	logic [63:0] wide_q;
	logic [63:0] acc_q;
	logic [1:0] off_q;
	logic [1:0] size_q;
	logic piece_hi_q;
	logic split2_q;
	logic cop_q;
	logic rd_valid_q;
	logic [31:0] rd_data_q;
	logic bus_start_q;
	logic bus_write_q;
	logic bus_mem_q;
	logic [3:0] lanes_n_q;
	logic [29:0] dw_q;
	logic [31:0] dout_q;
	logic oe_q;
	logic take;

	bls_req_buf u_buf (
		.clk(clk),
		.reset(reset),
		.in_valid(req_valid),
		.in_data(req),
		.in_ready(req_ready),
		.out_valid(head_valid),
		.out_data(head),
		.out_ready(take)
	);

	bls_lane_gen u_gen (
		.req(head),
		.lo_mask(gen_lo),
		.hi_mask(gen_hi),
		.base_dw(gen_dw),
		.wide(gen_wide)
	);

	// Sequencing decisions.
	wire [3:0] lanes_act = ~lanes_n_q;
	wire half = !half_width_port_n;
	wire upper_only = lanes_act[1:0] == 2'h0;
	assign take = (st_q == bls_pkg::ST_IDLE) && head_valid;
	wire at_end = (st_q == bls_pkg::ST_DATA) && !ready_n;
	wire split_now = at_end && half && lanes_act[1] && lanes_act[2]
		&& !split2_q;
	wire more_lo = at_end && !split_now && piece_hi_q
		&& lo_q != bls_pkg::LANES_NONE;
	wire done = at_end && !split_now && !more_lo;
	wire launch = take || split_now || more_lo;
	wire nxt_hi = take ? (gen_hi != bls_pkg::LANES_NONE) :
		split_now ? piece_hi_q : 1'b0;
	// Higher-order dword goes first when an operand spans two dwords.
	wire [3:0] nxt_lanes = take ? (nxt_hi ? gen_hi : gen_lo) :
		split_now ? (lanes_act & bls_pkg::LANES_UPPER) : lo_q;
	wire [29:0] nxt_base = take ? gen_dw : base_q;
	wire [29:0] nxt_dw = split_now ? dw_q :
		(nxt_hi ? nxt_base + 30'h00000001 : nxt_base);
	wire [63:0] wsrc = take ? gen_wide : wide_q;
	wire [31:0] wdw = nxt_hi ? wsrc[63:32] : wsrc[31:0];
	// Upper-only writes also present their bytes on the low half.
	wire [31:0] nxt_dout = (nxt_lanes[1:0] == 2'h0) ?
		{wdw[31:16], wdw[31:16]} : wdw;
	wire nxt_write = take ? head.write : bus_write_q;
	wire nxt_mem = take ? !(head.io || head.cop) : bus_mem_q;

	// Read byte capture, lane by lane.
	logic [31:0] cap;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
			wire [7:0] old = piece_hi_q ? acc_q[32 + 8 * gi +: 8] :
				acc_q[8 * gi +: 8];
			wire [7:0] src;
			if (gi < 2) begin : g_lo
				assign src = data_lines_in[8 * gi +: 8];
			end else begin : g_hi
				assign src = (half && upper_only) ?
					data_lines_in[8 * (gi - 2) +: 8] :
					data_lines_in[8 * gi +: 8];
			end
			assign cap[8 * gi +: 8] = lanes_act[gi] ? src : old;
		end
	endgenerate

	wire [63:0] acc_nx = piece_hi_q ? {cap, acc_q[31:0]} :
		{acc_q[63:32], cap};
	wire [63:0] shifted = acc_nx >> {off_q, 3'h0};
	wire [31:0] size_mask = (size_q == bls_pkg::SIZE_BYTE) ? 32'h000000FF :
		(size_q == bls_pkg::SIZE_WORD) ? 32'h0000FFFF : 32'hFFFFFFFF;
	wire [31:0] rd_result = shifted[31:0] & size_mask;

	assign rd_valid = rd_valid_q;
	assign rd_data = rd_data_q;
	assign bus_start = bus_start_q;
	assign bus_write = bus_write_q;
	assign bus_mem = bus_mem_q;
	assign byte_lane_select_n = lanes_n_q;
	assign dword_address = dw_q;
	assign data_lines_out = dout_q;
	assign data_lines_oe = oe_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			st_q <= bls_pkg::ST_IDLE;
		end else begin
			unique case (st_q)
				bls_pkg::ST_IDLE: if (take) st_q <= bls_pkg::ST_ADDR;
				bls_pkg::ST_ADDR: st_q <= bls_pkg::ST_DATA;
				bls_pkg::ST_DATA: begin
					if (launch) begin
						st_q <= bls_pkg::ST_ADDR;
					end else if (done) begin
						st_q <= bls_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Bus pins: all but bus_start held for the whole cycle, idle lanes all negated.
	always_ff @(posedge clk) begin
		if (reset) begin
			bus_start_q <= 1'b0;
			bus_write_q <= 1'b0;
			bus_mem_q <= 1'b0;
			lanes_n_q <= bls_pkg::LANES_SEL_IDLE_N;
			dw_q <= bls_pkg::RST_DWORD_ADDR;
			dout_q <= bls_pkg::RST_DATA;
			oe_q <= 1'b0;
			split2_q <= 1'b0;
			piece_hi_q <= 1'b0;
		end else if (launch) begin
			bus_start_q <= 1'b1;
			bus_write_q <= nxt_write;
			bus_mem_q <= nxt_mem;
			lanes_n_q <= ~nxt_lanes;
			dw_q <= nxt_dw;
			dout_q <= nxt_dout;
			oe_q <= nxt_write;
			split2_q <= split_now;
			piece_hi_q <= nxt_hi;
		end else begin
			bus_start_q <= 1'b0;
			if (done) begin
				lanes_n_q <= bls_pkg::LANES_SEL_IDLE_N;
				oe_q <= 1'b0;
				split2_q <= 1'b0;
			end
		end
	end

	// Operand context for the whole transfer.
	always_ff @(posedge clk) begin
		if (take) begin
			lo_q <= gen_lo;
			base_q <= gen_dw;
			wide_q <= gen_wide;
			off_q <= head.addr[1:0];
			size_q <= head.size;
			cop_q <= head.cop;
		end
		if (at_end) begin
			acc_q <= acc_nx;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= bls_pkg::RST_DATA;
		end else begin
			rd_valid_q <= done && !bus_write_q;
			if (done && !bus_write_q) begin
				rd_data_q <= rd_result;
			end
		end
	end

	property p_lane_idle;
		@(posedge clk) disable iff (reset)
		st_q == bls_pkg::ST_IDLE |-> byte_lane_select_n == 4'hF;
	endproperty
	a_lane_idle: assert property (p_lane_idle)
		else $error("Lane select asserted outside a bus cycle.");

	property p_lane_contig;
		@(posedge clk) disable iff (reset)
		!(lanes_act inside {4'h5, 4'h9, 4'hA, 4'hB, 4'hD});
	endproperty
	a_lane_contig: assert property (p_lane_contig)
		else $error("Lane selects are not contiguous.");

	property p_min_states;
		@(posedge clk) disable iff (reset)
		bus_start |=> !bus_start && st_q == bls_pkg::ST_DATA;
	endproperty
	a_min_states: assert property (p_min_states)
		else $error("Bus cycle shorter than two states.");

	property p_io_range;
		@(posedge clk) disable iff (reset)
		bus_start && !bus_mem && !cop_q |-> dword_address[29:14] == 16'h0000;
	endproperty
	a_io_range: assert property (p_io_range)
		else $error("Programmed I/O address above 64 KB.");

	property p_cop_addr;
		@(posedge clk) disable iff (reset)
		bus_start && cop_q
		|-> !bus_mem && dword_address[29:1] == 29'h1000001F;
	endproperty
	a_cop_addr: assert property (p_cop_addr)
		else $error("Coprocessor cycle at wrong address.");

	property p_upper_copy;
		@(posedge clk) disable iff (reset)
		st_q != bls_pkg::ST_IDLE && bus_write && lanes_act[1:0] == 2'h0
		|-> data_lines_oe && data_lines_out[15:0] == data_lines_out[31:16];
	endproperty
	a_upper_copy: assert property (p_upper_copy)
		else $error("Upper-only write not copied to low lines.");

	property p_split_follow;
		@(posedge clk) disable iff (reset)
		split_now |=> bus_start && lanes_act == ($past(lanes_act) & 4'hC)
			&& dword_address == $past(dword_address);
	endproperty
	a_split_follow: assert property (p_split_follow)
		else $error("Split second cycle not issued as expected.");

	property p_split_low_off;
		@(posedge clk) disable iff (reset)
		split2_q && st_q != bls_pkg::ST_IDLE
		|-> byte_lane_select_n[1:0] == 2'h3;
	endproperty
	a_split_low_off: assert property (p_split_low_off)
		else $error("Low lanes asserted in second split cycle.");

	property p_low_only;
		@(posedge clk) disable iff (reset)
		at_end && lanes_act[3:2] == 2'h0
		|-> !split_now ##1 ($past(piece_hi_q) || st_q == bls_pkg::ST_IDLE);
	endproperty
	a_low_only: assert property (p_low_only)
		else $error("Half-width input split a low-half cycle.");

	property p_read_done;
		@(posedge clk) disable iff (reset)
		done && !bus_write |=> rd_valid ##1 !rd_valid;
	endproperty
	a_read_done: assert property (p_read_done)
		else $error("Read result not returned after last cycle.");
endmodule // bls_bus_sizer

// ===== include/bls_pkg.sv
package bls_pkg;

	// Transfer sizes of a logical operand.
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_DWORD = 2'h2;

	// Lane masks, active high inside the block.
	localparam logic [3:0] LANES_NONE = 4'h0;
	localparam logic [3:0] LANES_UPPER = 4'hC;
	localparam logic [3:0] LANES_SEL_IDLE_N = 4'hF;
	localparam logic [3:0] MASK_BYTE = 4'h1;
	localparam logic [3:0] MASK_WORD = 4'h3;
	localparam logic [3:0] MASK_DWORD = 4'hF;

	// Address spaces.
	localparam logic [31:0] IO_ADDR_MASK = 32'h0000FFFF;
	localparam logic [31:0] COP_IO_BASE = 32'h800000F8;
	localparam logic [31:0] COP_IO_OFS_MASK = 32'h00000007;

	// Reset values of the bus outputs.
	localparam logic [29:0] RST_DWORD_ADDR = 30'h00000000;
	localparam logic [31:0] RST_DATA = 32'h00000000;

	// Bus timing: one bus state is one clock of 20 ns.
	localparam int CLK_PERIOD_NS = 20;
	localparam int BUS_STATE_NS = 20;
	localparam int MIN_BUS_STATES = 2;
	localparam int MIN_CYCLE_CLKS =
		(MIN_BUS_STATES * BUS_STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic [31:0] addr;
		logic [1:0] size;
		logic write;
		logic io;
		logic cop;
		logic [31:0] wdata;
	} bls_req_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA
	} bls_state_t;

endpackage

// ===== design/bls_req_buf.sv
`timescale 1ns/1ps
// Two-entry request buffer; its output word is always a register.
module bls_req_buf (
	clk,
	reset,
	in_valid,
	in_data,
	in_ready,
	out_valid,
	out_data,
	out_ready
);
	input wire logic clk;
	input wire logic reset;
	input wire logic in_valid;
	input bls_pkg::bls_req_t in_data;
	output logic in_ready;
	output logic out_valid;
	output bls_pkg::bls_req_t out_data;
	input wire logic out_ready;

	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic ready_q;
	bls_pkg::bls_req_t e0_q;
	bls_pkg::bls_req_t e1_q;
	wire push = in_valid && ready_q;
	wire pop = (cnt_q != 2'h0) && out_ready;

	assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	assign in_ready = ready_q;
	assign out_valid = cnt_q != 2'h0;
	assign out_data = e0_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= 2'h0;
			ready_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			ready_q <= cnt_d != 2'h2;
		end
	end

	always_ff @(posedge clk) begin
		if (pop && cnt_q == 2'h2) begin
			e0_q <= e1_q;
		end else if (push && (cnt_q == 2'h0 || pop)) begin
			e0_q <= in_data;
		end
		if (push && cnt_q == 2'h1 && !pop) begin
			e1_q <= in_data;
		end
	end
endmodule // bls_req_buf

// ===== design/bls_lane_gen.sv
`timescale 1ns/1ps
// Maps an operand onto one or two physical dwords.
module bls_lane_gen (
	req,
	lo_mask,
	hi_mask,
	base_dw,
	wide
);
	input bls_pkg::bls_req_t req;
	output logic [3:0] lo_mask;
	output logic [3:0] hi_mask;
	output logic [29:0] base_dw;
	output logic [63:0] wide;

	logic [31:0] eff;
	logic [3:0] nmask;
	logic [7:0] m8;

	// Programmed I/O stays in 64 KB; coprocessor cycles sit at 800000F8-800000FF.
	assign eff = req.cop ?
		(bls_pkg::COP_IO_BASE | (req.addr & bls_pkg::COP_IO_OFS_MASK)) :
		req.io ? (req.addr & bls_pkg::IO_ADDR_MASK) : req.addr;
	assign nmask = (req.size == bls_pkg::SIZE_BYTE) ? bls_pkg::MASK_BYTE :
		(req.size == bls_pkg::SIZE_WORD) ? bls_pkg::MASK_WORD :
		bls_pkg::MASK_DWORD;
	assign m8 = {4'h0, nmask} << eff[1:0];
	assign lo_mask = m8[3:0];
	assign hi_mask = m8[7:4];
	assign base_dw = eff[31:2];
	assign wide = {32'h00000000, req.wdata} << {eff[1:0], 3'h0};
endmodule // bls_lane_gen

// ===== tb/bls_slave_model.sv
`timescale 1ns/1ps
// Slave and decoder: dword bit 6 set selects a 16-bit port.
module bls_slave_model (
	clk,
	reset,
	waits,
	bus_start,
	bus_write,
	lanes_n,
	dw,
	dout,
	din,
	half_n,
	ready_n
);
	input wire logic clk;
	input wire logic reset;
	input wire logic [1:0] waits;
	input wire logic bus_start;
	input wire logic bus_write;
	input wire logic [3:0] lanes_n;
	input wire logic [29:0] dw;
	input wire logic [31:0] dout;
	output logic [31:0] din;
	output logic half_n;
	output logic ready_n;
	logic [31:0] mem [64];
	logic active;
	logic lo;
	logic [1:0] cnt;
	logic [3:0] ln;
	logic [15:0] h;
	assign ln = ~lanes_n;
	assign lo = ln[1:0] != 2'h0;
	assign half_n = ~dw[6];
	assign ready_n = !(active && cnt == 2'h0);
	assign h = lo ? mem[dw[5:0]][15:0] : mem[dw[5:0]][31:16];
	assign din = ready_n ? ~mem[dw[5:0]] : (half_n ? mem[dw[5:0]] : {~h, h});
	always_ff @(posedge clk) begin
		if (reset) begin
			active <= 1'b0;
			cnt <= 2'h0;
		end else if (bus_start) begin
			active <= 1'b1;
			cnt <= waits;
		end else if (active && cnt == 2'h0) begin
			active <= 1'b0;
		end else if (active) begin
			cnt <= cnt - 2'h1;
		end
	end
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (!ready_n && bus_write && ln[i] && half_n) begin
				mem[dw[5:0]][i*8+:8] <= dout[i*8+:8];
			end
			if (!ready_n && bus_write && ln[i] && !half_n && lo == (i < 2)) begin
				mem[dw[5:0]][i*8+:8] <= dout[(i%2)*8+:8];
			end
		end
	end
endmodule // bls_slave_model

// ===== tb/bls_bus_sizer_tb.sv
`timescale 1ns/1ps
module bls_bus_sizer_tb;
	logic clk, reset, req_valid, req_ready, rd_valid, bus_start, bus_write;
	logic bus_mem, oe, half_n, ready_n;
	logic open = 1'b0;
	bls_pkg::bls_req_t req;
	logic [31:0] rd_data, din, dout, got;
	logic [3:0] lanes_n;
	logic [29:0] dw;
	logic [1:0] waits;
	int mismatches, checks_done, cycles, stalls;
	logic [3:0] lq[$];
	logic [29:0] aq[$];
	logic mq[$];

	bls_bus_sizer i_bls_bus_sizer (.clk(clk), .reset(reset),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rd_valid(rd_valid), .rd_data(rd_data), .bus_start(bus_start),
		.bus_write(bus_write), .bus_mem(bus_mem),
		.byte_lane_select_n(lanes_n), .dword_address(dw),
		.data_lines_in(din), .data_lines_out(dout), .data_lines_oe(oe),
		.half_width_port_n(half_n), .ready_n(ready_n));
	bls_slave_model i_bls_slave_model (.clk(clk), .reset(reset),
		.waits(waits), .bus_start(bus_start), .bus_write(bus_write),
		.lanes_n(lanes_n), .dw(dw), .dout(dout), .din(din),
		.half_n(half_n), .ready_n(ready_n));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] e,
		input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, e, s);
		end
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			$display("unexpected cycles: expected below 4000, seen 4000");
			report_and_stop();
		end
	end

	always @(posedge clk) begin
		if (req_valid && !req_ready) stalls++;
		if (!ready_n) open <= 1'b0;
		if (bus_start) begin
			check("overlap", 32'h0, open);
			check("oe", bus_write, oe);
			open <= 1'b1;
			lq.push_back(lanes_n);
			aq.push_back(dw);
			mq.push_back(bus_mem);
			check("contiguous", 32'h1, ~lanes_n inside {4'h1, 4'h2, 4'h3,
				4'h4, 4'h6, 4'h7, 4'h8, 4'hC, 4'hE, 4'hF});
			if (bus_write && lanes_n[1:0] == 2'h3)
				check("copy", dout[31:16], dout[15:0]);
		end
	end

	task automatic push(input bls_pkg::bls_req_t r);
		req = r;
		req_valid = 1'b1;
		do @(posedge clk); while (req_ready !== 1'b1);
		#1;
	endtask

	task automatic op(input logic [31:0] a, input logic [1:0] sz,
		input logic wr, input logic io, input logic cp, input logic [31:0] wd);
		int idle;
		lq.delete();
		aq.delete();
		mq.delete();
		got = 32'hFFFFFFFF;
		push('{a, sz, wr, io, cp, wd});
		req_valid = 1'b0;
		idle = 0;
		while (idle < 6) begin
			@(posedge clk);
			#1;
			if (rd_valid === 1'b1) got = rd_data;
			idle = (open || bus_start || !req_ready) ? 0 : idle + 1;
		end
	endtask

	task automatic t_plain();
		op(32'h10000010, bls_pkg::SIZE_DWORD, 1, 0, 0, 32'h11223344);
		check("lanes", 32'h0, lq[0]);
		check("dword", 32'h04000004, aq[0]);
		op(32'h00000023, bls_pkg::SIZE_DWORD, 1, 0, 0, 32'hCAFEF00D);
		check("count", 32'h2, lq.size());
		check("lanes", 32'h8, lq[0]);
		check("dword", 32'h9, aq[0]);
		check("lanes", 32'h7, lq[1]);
		op(32'h00000023, bls_pkg::SIZE_DWORD, 0, 0, 0, 32'h0);
		check("data", 32'hCAFEF00D, got);
		$display("plain done");
	endtask

	task automatic t_split();
		op(32'h00000100, bls_pkg::SIZE_DWORD, 1, 0, 0, 32'hA5B6C7D8);
		check("count", 32'h2, lq.size());
		check("lanes", 32'h3, lq[1]);
		op(32'h00000100, bls_pkg::SIZE_DWORD, 0, 0, 0, 32'h0);
		check("data", 32'hA5B6C7D8, got);
		check("lanes", 32'h3, lq[1]);
		op(32'h00000101, bls_pkg::SIZE_BYTE, 0, 0, 0, 32'h0);
		check("data", 32'hC7, got);
		check("count", 32'h1, lq.size());
		op(32'h00000106, bls_pkg::SIZE_WORD, 1, 0, 0, 32'hBEEF);
		check("lanes", 32'h3, lq[0]);
		op(32'h00000106, bls_pkg::SIZE_WORD, 0, 0, 0, 32'h0);
		check("data", 32'hBEEF, got);
		op(32'h10000012, bls_pkg::SIZE_WORD, 0, 0, 0, 32'h0);
		check("data", 32'h1122, got);
		$display("split done");
	endtask

	task automatic t_space();
		op(32'h12345679, bls_pkg::SIZE_BYTE, 1, 1, 0, 32'h5A);
		check("dword", 32'h159E, aq[0]);
		check("memory", 32'h0, mq[0]);
		check("lanes", 32'hD, lq[0]);
		op(32'h00000005, bls_pkg::SIZE_BYTE, 1, 0, 1, 32'h77);
		check("dword", 32'h2000003F, aq[0]);
		check("memory", 32'h0, mq[0]);
		$display("space done");
	endtask

	task automatic t_buffer();
		waits = 2'h3;
		stalls = 0;
		for (int i = 0; i < 4; i++)
			push('{32'h30 + 4 * i, bls_pkg::SIZE_DWORD, 1'b1, 1'b0, 1'b0,
				32'h0F1E2D00 + i});
		for (int i = 0; i < 4; i++) begin
			op(32'h30 + 4 * i, bls_pkg::SIZE_DWORD, 0, 0, 0, 32'h0);
			check("data", 32'h0F1E2D00 + i, got);
		end
		check("stall", 32'h1, stalls > 0);
		waits = 2'h0;
		$display("buffer done");
	endtask

	initial begin
		reset = 1'b1;
		req_valid = 1'b0;
		req = '0;
		waits = 2'h0;
		repeat (10) @(posedge clk);
		#1;
		reset = 1'b0;
		t_plain();
		t_split();
		t_space();
		t_buffer();
		report_and_stop();
	end
endmodule // bls_bus_sizer_tb
